// *** logic/flash_host_pkg.sv ***
// Constants, command codes and carrier types for the flash host controller
package flash_host_pkg;
    // Timing of one asynchronous bus cycle
    localparam int       CLK_NS        = 20;
    localparam int       T_STROBE_NS   = 60;
    localparam logic [2:0] STROBE_CYC  = 3'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);

    // Software register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_ADDR    = 8'h04;
    localparam logic [7:0] OFF_DATA    = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_RESULT  = 8'h10;

    // Status register field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_FAIL  = 1;
    localparam int ST_READY = 2;
    localparam int ST_DONE  = 3;

    // Data bit positions of the status bits on the flash data bus
    localparam int POLL_BIT    = 7;
    localparam int TOGGLE_BIT  = 6;
    localparam int TIMEOUT_BIT = 5;

    // Host operation codes written to the control register
    localparam logic [3:0] OP_READ       = 4'h0;
    localparam logic [3:0] OP_RESET      = 4'h1;
    localparam logic [3:0] OP_PROGRAM    = 4'h2;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h3;
    localparam logic [3:0] OP_SECT_ERASE = 4'h4;
    localparam logic [3:0] OP_AUTOSELECT = 4'h5;
    localparam logic [3:0] OP_BYP_ENTER  = 4'h6;
    localparam logic [3:0] OP_BYP_PROG   = 4'h7;
    localparam logic [3:0] OP_BYP_RESET  = 4'h8;
    localparam logic [3:0] OP_SUSPEND    = 4'h9;
    localparam logic [3:0] OP_RESUME     = 4'ha;

    // Unlock addresses and command data (word mode)
    localparam logic [18:0] UNLOCK_A1  = 19'h00555;
    localparam logic [18:0] UNLOCK_A2  = 19'h002aa;
    localparam logic [15:0] D_UNLOCK1  = 16'h00aa;
    localparam logic [15:0] D_UNLOCK2  = 16'h0055;
    localparam logic [15:0] D_PROGRAM  = 16'h00a0;
    localparam logic [15:0] D_ERASE    = 16'h0080;
    localparam logic [15:0] D_CHIP     = 16'h0010;
    localparam logic [15:0] D_SECTOR   = 16'h0030;
    localparam logic [15:0] D_AUTOSEL  = 16'h0090;
    localparam logic [15:0] D_BYPASS   = 16'h0020;
    localparam logic [15:0] D_BYP_EXIT = 16'h0000;
    localparam logic [15:0] D_RESET    = 16'h00f0;
    localparam logic [15:0] D_SUSPEND  = 16'h00b0;
    localparam logic [15:0] D_RESUME   = 16'h0030;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Flash pins driven by the host
    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [18:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe;
    } flash_pins_t;

    // One bus cycle of a command sequence
    typedef struct packed {
        logic        last;
        logic        wr;
        logic [18:0] addr;
        logic [15:0] data;
    } cyc_t;
endpackage : flash_host_pkg

// *** logic/flash_bus_cycle.sv ***
// One asynchronous flash read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        start,
    input  wire cyc_t        cyc,
    input  wire logic [15:0] dq_i,
    output flash_pins_t      pins,
    output logic             done,
    output logic [15:0]      rdata
);
    typedef enum logic [3:0] {
        C_IDLE   = 4'b0001,
        C_SETUP  = 4'b0010,
        C_STROBE = 4'b0100,
        C_HOLD   = 4'b1000
    } cstate_t;

    cstate_t     state_reg;
    logic [2:0]  cnt_reg;
    logic        wr_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= C_IDLE;
            cnt_reg   <= 3'h0;
            wr_reg    <= 1'b0;
            done      <= 1'b0;
            rdata     <= 16'h0000;
            pins      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 19'h00000,
                           dq_o: 16'h0000, dq_oe: 1'b0};
        end else begin
            done <= 1'b0;
            case (state_reg)
                C_IDLE: begin
                    if (start) begin
                        // Address and data settle before any strobe falls
                        pins.ce_n  <= 1'b0;
                        pins.addr  <= cyc.addr;
                        pins.dq_o  <= cyc.data;
                        pins.dq_oe <= cyc.wr;
                        wr_reg     <= cyc.wr;
                        state_reg  <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    // Write strobe falls after chip select: it latches the address
                    pins.we_n <= !wr_reg;
                    pins.oe_n <= wr_reg;
                    cnt_reg   <= STROBE_CYC;
                    state_reg <= C_STROBE;
                end
                C_STROBE: begin
                    if (cnt_reg == 3'h1) begin
                        // Write strobe rises first, chip select next: data latch
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        rdata     <= wr_reg ? rdata : dq_i;
                        state_reg <= C_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 3'h1;
                    end
                end
                C_HOLD: begin
                    pins.ce_n  <= 1'b1;
                    pins.dq_oe <= 1'b0;
                    done       <= 1'b1;
                    state_reg  <= C_IDLE;
                end
                default: state_reg <= C_IDLE;
            endcase
        end
    end

    strobe_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(!pins.we_n && !pins.oe_n)) else $error("write and read strobes both low");
    addr_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(pins.we_n) |-> pins.addr == $past(pins.addr) && !pins.ce_n)
        else $error("address moved at write strobe fall");
    data_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(pins.we_n) |-> pins.dq_oe && pins.dq_o == $past(pins.dq_o) && !pins.ce_n)
        else $error("write data not held through strobe rise");
    strobe_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
        else $error("write strobe width wrong");
    write_cov: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pins.we_n));
    read_cov: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pins.oe_n));
endmodule : flash_bus_cycle

// *** logic/flash_host_ctrl.sv ***
// Flash host controller: command sequences, status polling and AXI4-Lite registers
`timescale 1ns/10ps
module flash_host_ctrl
    import flash_host_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output flash_pins_t      flash_pins,
    input  wire logic [15:0] flash_dq_i,
    output logic             flash_reset_n,
    input  wire logic        ready_busy_n
);
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_RUN    = 6'b000010,
        S_POLL_A = 6'b000100,
        S_POLL_B = 6'b001000,
        S_FINAL  = 6'b010000,
        S_RESET  = 6'b100000
    } state_t;

    // Bits 18..12 select the sector; lower bits are don't care
    function automatic logic [18:0] sector_address(input logic [18:0] a);
        return {a[18:12], 12'h000};
    endfunction : sector_address

    // Bus cycle number step of operation op
    function automatic cyc_t seq_step(input logic [3:0] op, input logic [2:0] step,
                                      input logic [18:0] a, input logic [15:0] d);
        cyc_t c;
        c = '{last: 1'b0, wr: 1'b1, addr: UNLOCK_A1, data: D_UNLOCK1};
        // Unlock cycles carry only low address bits
        if (step == 3'h1 || step == 3'h4) begin
            c.addr = UNLOCK_A2;
            c.data = D_UNLOCK2;
        end
        case (op)
            OP_READ: c = '{last: 1'b1, wr: 1'b0, addr: a, data: 16'h0000};
            OP_RESET: c = '{last: 1'b1, wr: 1'b1, addr: 19'h00000, data: D_RESET};
            OP_SUSPEND: c = '{last: 1'b1, wr: 1'b1, addr: 19'h00000, data: D_SUSPEND};
            OP_RESUME: c = '{last: 1'b1, wr: 1'b1, addr: 19'h00000, data: D_RESUME};
            OP_PROGRAM: begin
                if (step == 3'h2) c.data = D_PROGRAM;
                if (step == 3'h3) c = '{last: 1'b1, wr: 1'b1, addr: a, data: d};
            end
            OP_BYP_ENTER, OP_AUTOSELECT: begin
                if (step == 3'h2) begin
                    c.data = (op == OP_AUTOSELECT) ? D_AUTOSEL : D_BYPASS;
                    c.last = (op == OP_BYP_ENTER);
                end
                if (step == 3'h3) c = '{last: 1'b1, wr: 1'b0, addr: a, data: 16'h0000};
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                if (step == 3'h2) c.data = D_ERASE;
                if (step == 3'h5) begin
                    c.last = 1'b1;
                    c.data = (op == OP_CHIP_ERASE) ? D_CHIP : D_SECTOR;
                    if (op == OP_SECT_ERASE) c.addr = sector_address(a);
                end
            end
            OP_BYP_PROG: begin
                c = '{last: 1'b0, wr: 1'b1, addr: 19'h00000, data: D_PROGRAM};
                if (step == 3'h1) c = '{last: 1'b1, wr: 1'b1, addr: a, data: d};
            end
            OP_BYP_RESET: begin
                c = '{last: 1'b0, wr: 1'b1, addr: 19'h00000, data: D_AUTOSEL};
                if (step == 3'h1) c.data = D_BYP_EXIT;
                c.last = (step == 3'h1);
            end
            default: c.last = 1'b1;
        endcase
        return c;
    endfunction : seq_step

    state_t      state_reg;
    logic [3:0]  op_reg;
    logic [2:0]  step_reg;
    logic [18:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] result_reg;
    logic [15:0] first_reg;
    logic        recheck_reg;
    logic        go_reg;
    logic        fail_reg;
    logic        done_reg;
    logic        bpend_reg;
    logic        bresp_bad_reg;
    logic        cyc_done;
    logic [15:0] cyc_rdata;

    // Register decode
    wire         wr_fire  = s_axi_awvalid && s_axi_wvalid && !bpend_reg;
    wire         rd_fire  = s_axi_arvalid && !s_axi_rvalid;
    wire         ctrl_hit = wr_fire && s_axi_awaddr == OFF_CTRL && s_axi_wstrb[0];
    wire         wr_ok    = s_axi_awaddr == OFF_CTRL || s_axi_awaddr == OFF_ADDR ||
                            s_axi_awaddr == OFF_DATA;
    wire         busy     = state_reg != S_IDLE;
    wire [31:0]  status_word = {28'h0000000, done_reg, ready_busy_n, fail_reg, busy};
    wire         rd_ok    = s_axi_araddr <= OFF_RESULT && s_axi_araddr[1:0] == 2'h0;
    wire [31:0]  rd_word  = (s_axi_araddr == OFF_ADDR)   ? {13'h0000, addr_reg} :
                            (s_axi_araddr == OFF_DATA)   ? {16'h0000, data_reg} :
                            (s_axi_araddr == OFF_STATUS) ? status_word :
                            (s_axi_araddr == OFF_RESULT) ? {16'h0000, result_reg} :
                            {28'h0000000, op_reg};
    wire         needs_poll = op_reg == OP_PROGRAM || op_reg == OP_BYP_PROG ||
                              op_reg == OP_CHIP_ERASE || op_reg == OP_SECT_ERASE;

    // Command cycles are writes except the OP_READ cycle and the last autoselect cycle; polls read at the operation's own address
    wire cyc_t   step_cyc = seq_step(op_reg, step_reg, addr_reg, data_reg);
    wire cyc_t   poll_cyc = '{last: 1'b1, wr: 1'b0, addr: addr_reg, data: 16'h0000};
    wire cyc_t   rst_cyc  = '{last: 1'b1, wr: 1'b1, addr: 19'h00000, data: D_RESET};
    wire cyc_t   cur_cyc  = (state_reg == S_RUN)   ? step_cyc :
                            (state_reg == S_RESET) ? rst_cyc : poll_cyc;
    wire         toggling = cyc_rdata[TOGGLE_BIT] != first_reg[TOGGLE_BIT];

    flash_bus_cycle u_cycle (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (go_reg),
        .cyc     (cur_cyc),
        .dq_i    (flash_dq_i),
        .pins    (flash_pins),
        .done    (cyc_done),
        .rdata   (cyc_rdata)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
            bpend_reg     <= 1'b0;
            bresp_bad_reg <= 1'b0;
            flash_reset_n <= 1'b0;
            addr_reg      <= 19'h00000;
            data_reg      <= 16'h0000;
        end else begin
            flash_reset_n <= 1'b1;
            s_axi_awready <= wr_fire;
            s_axi_wready  <= wr_fire;
            s_axi_arready <= rd_fire;
            if (wr_fire) begin
                bpend_reg <= 1'b1;
                if (s_axi_awaddr == OFF_ADDR) addr_reg <= s_axi_wdata[18:0];
                if (s_axi_awaddr == OFF_DATA) data_reg <= s_axi_wdata[15:0];
                bresp_bad_reg <= !wr_ok;
            end
            // Response one cycle after both channels are taken
            if (bpend_reg && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= bresp_bad_reg ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                bpend_reg    <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_word : 32'h00000000;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sequencer; a control write while busy is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= S_IDLE;
            op_reg      <= OP_READ;
            step_reg    <= 3'h0;
            go_reg      <= 1'b0;
            fail_reg    <= 1'b0;
            done_reg    <= 1'b0;
            recheck_reg <= 1'b0;
            first_reg   <= 16'h0000;
            result_reg  <= 16'h0000;
        end else begin
            go_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (ctrl_hit) begin
                        op_reg      <= s_axi_wdata[3:0];
                        step_reg    <= 3'h0;
                        fail_reg    <= 1'b0;
                        done_reg    <= 1'b0;
                        recheck_reg <= 1'b0;
                        go_reg      <= 1'b1;
                        state_reg   <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (cyc_done) begin
                        go_reg <= 1'b1;
                        if (!step_cyc.last) begin
                            step_reg <= step_reg + 3'h1;
                        end else if (!step_cyc.wr) begin
                            result_reg <= cyc_rdata;
                            go_reg     <= 1'b0;
                            done_reg   <= 1'b1;
                            state_reg  <= S_IDLE;
                        end else if (needs_poll) begin
                            state_reg <= S_POLL_A;
                        end else begin
                            go_reg    <= 1'b0;
                            done_reg  <= 1'b1;
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_POLL_A: begin
                    if (cyc_done) begin
                        first_reg <= cyc_rdata;
                        go_reg    <= 1'b1;
                        state_reg <= S_POLL_B;
                    end
                end
                S_POLL_B: begin
                    if (cyc_done) begin
                        go_reg <= 1'b1;
                        if (!toggling) begin
                            state_reg <= S_FINAL;
                        end else if (recheck_reg) begin
                            state_reg <= S_RESET;
                        end else begin
                            // Timeout bit may rise as toggling stops: recheck once
                            recheck_reg <= cyc_rdata[TIMEOUT_BIT];
                            state_reg   <= S_POLL_A;
                        end
                    end
                end
                S_FINAL: begin
                    if (cyc_done) begin
                        result_reg <= cyc_rdata;
                        done_reg   <= 1'b1;
                        state_reg  <= S_IDLE;
                    end
                end
                S_RESET: begin
                    if (cyc_done) begin
                        fail_reg  <= 1'b1;
                        done_reg  <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    start_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_IDLE && ctrl_hit |=> state_reg == S_RUN && go_reg)
        else $error("control write did not start a command");
    unlock_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_RUN && op_reg == OP_PROGRAM && step_reg < 3'h3 |->
        cur_cyc.addr[18:11] == 8'h00) else $error("unlock cycle carries high address");
    sector_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_RUN && op_reg == OP_SECT_ERASE && step_reg == 3'h5 |->
        cur_cyc.addr == {addr_reg[18:12], 12'h000} && cur_cyc.data == D_SECTOR)
        else $error("sector erase cycle has wrong sector address");
    poll_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == S_POLL_A || state_reg == S_POLL_B) |->
        !cur_cyc.wr && cur_cyc.addr == addr_reg) else $error("poll read at wrong address");
    fail_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_POLL_B && cyc_done && toggling && recheck_reg |=>
        state_reg == S_RESET ##0 cur_cyc.data == D_RESET && go_reg)
        else $error("failed operation not followed by reset");
    reread_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_POLL_B && cyc_done && !toggling |=> state_reg == S_FINAL ##1
        !cur_cyc.wr) else $error("no full reread after polling ended");
    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    program_cov: cover property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_FINAL && op_reg == OP_PROGRAM && cyc_done);
    fail_cov: cover property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_RESET && cyc_done);
    autosel_cov: cover property (@(posedge aclk) disable iff (!aresetn)
        state_reg == S_RUN && op_reg == OP_AUTOSELECT && step_reg == 3'h3 && cyc_done);
endmodule : flash_host_ctrl

// *** tb/flash_dev_model.sv ***
// Behavioural flash device facing the host controller
`timescale 1ns/10ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int          BUSY_CYC = 30,
    parameter logic [15:0] ID_CODE  = 16'h00c3 // Arbitrary value
)(
    input  wire flash_pins_t pins,
    output logic [15:0]      dq,
    output logic             ready_busy_n
);
    logic [15:0] mem [0:255];
    logic [15:0] pd, last = 16'h0;
    logic [18:0] al;
    logic        tog = 1'b0, asel = 1'b0, fl = 1'b0, ers = 1'b0, byp = 1'b0, sus = 1'b0;
    int          st = 0, busy = 0;
    wire         wr_n = pins.we_n | pins.ce_n;
    wire         rd = ~(pins.oe_n | pins.ce_n);
    wire  [15:0] idv = pins.addr[1:0] == 2'h2 ? 16'h0000 : ID_CODE;
    // Erase covers the whole model array, so every read sees status while busy
    wire  [15:0] stv = {8'h00, ers ? sus : ~pd[7], tog, fl, 5'h00};
    wire  [15:0] drv = busy > 0 ? stv : asel ? idv : mem[pins.addr[7:0]];
    initial foreach (mem[i]) mem[i] = 16'hffff;
    // A failed program holds busy until the reset command
    always #20 if (busy > 0 && !fl && !sus) busy = busy - 1;
    always @(negedge wr_n) al = pins.addr;
    always @(posedge wr_n) begin
        pd = pins.dq_o;
        if (st == 3) begin
            // Programming a 1 over a 0 cannot succeed
            fl = |(pd & ~mem[al[7:0]]);
            if (!fl) mem[al[7:0]] = pd;
            ers = 1'b0;
            busy = BUSY_CYC;
            st = 0;
        end else if (st == 6 && (pd == D_CHIP || pd == D_SECTOR)) begin
            foreach (mem[i]) mem[i] = 16'hffff;
            ers = 1'b1;
            busy = BUSY_CYC;
            st = 0;
        end else if (pd == D_RESET) begin
            asel = 1'b0;
            if (fl) busy = 0;
            fl = 1'b0;
            st = 0;
        end else if (pd == D_UNLOCK1) st = (st == 4) ? 5 : 1;
        else if (st == 1 && pd == D_UNLOCK2) st = 2;
        else if (st == 5 && pd == D_UNLOCK2) st = 6;
        else if (pd == D_PROGRAM && (st == 2 || byp)) st = 3;
        else if (byp && pd == D_AUTOSEL) st = 7;
        else if (st == 7 && pd == D_BYP_EXIT) byp = 1'b0;
        else if (st == 2 && pd == D_ERASE) st = 4;
        else if (st == 2 && pd == D_AUTOSEL) asel = 1'b1;
        else if (st == 2 && pd == D_BYPASS) byp = 1'b1;
        else if (pd == D_SUSPEND && ers && busy > 0) sus = 1'b1;
        else if (pd == D_RESUME && sus) sus = 1'b0;
        else st = 0;
    end
    // Released bus never shows the last value
    always @(negedge rd) begin
        last = drv;
        if (busy > 0 && !sus) tog = ~tog;
    end
    assign dq = rd ? drv : ~last;
    assign ready_busy_n = busy == 0 || sus;
endmodule : flash_dev_model

// *** tb/flash_host_ctrl_tb.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_tb;
    import flash_host_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, quiet = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got, seed = 32'hbb68;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_wready, flash_reset_n;
    logic        s_axi_awready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready_busy_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] dq, flash_dq_i, d;
    logic [18:0] a;
    logic [33:0] obs, expq [$];
    flash_pins_t flash_pins;
    int          num_errors = 0, comparisons = 0;
    initial forever #10 aclk = ~aclk;
    flash_host_ctrl u_flash_host_ctrl (.*);
    flash_dev_model u_flash_dev_model (.pins(flash_pins), .dq, .ready_busy_n);
    assign flash_dq_i = flash_pins.dq_oe ? flash_pins.dq_o : dq;
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && !quiet || s_axi_bvalid && s_axi_bready) begin
            obs = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
            comparisons++;
            if (obs !== expq[0]) begin
                num_errors++;
                $display("[ERR] %0t got %h exp %h", $time, obs, expq[0]);
            end
            void'(expq.pop_front());
        end
    end
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd, input logic [1:0] r);
        @(posedge aclk);
        expq.push_back({r, 32'h0});
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [33:0] e);
        @(posedge aclk);
        if (!quiet) expq.push_back(e);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
    endtask : rd
    task automatic op(input logic [18:0] fa, input logic [15:0] fd, input logic [3:0] c);
        wr(OFF_ADDR, 32'(fa), RESP_OKAY);
        wr(OFF_DATA, 32'(fd), RESP_OKAY);
        wr(OFF_CTRL, 32'(c), RESP_OKAY);
        quiet = 1'b1;
        do rd(OFF_STATUS, 34'h0); while (got[ST_DONE] !== 1'b1);
        @(negedge aclk);
        quiet = 1'b0;
    endtask : op
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_STATUS, 34'h4);
        comparisons++;
        if (flash_reset_n !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t reset pin %h exp %h", $time, flash_reset_n, 1'b1);
        end
        rd(8'h14, {RESP_SLVERR, 32'h0});
        wr(8'h20, 32'h0, RESP_SLVERR);
        $display("test register map done");
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            // Low address bits from the index keep the four targets apart
            a = {seed[18:2], i[1:0]};
            d = seed[31:16];
            op(a, d, OP_PROGRAM);
            rd(OFF_RESULT, {18'h0, d});
            rd(OFF_STATUS, 34'hc);
            op(a ^ 19'h7ff00, 16'h0, OP_READ);
            rd(OFF_RESULT, {18'h0, d});
            $display("test program %0d done", i);
        end
        op(a, 16'hffff, OP_PROGRAM);
        rd(OFF_STATUS, 34'he);
        op(a, 16'h0, OP_SECT_ERASE);
        rd(OFF_RESULT, 34'hffff);
        op(19'h0, 16'h0, OP_BYP_ENTER);
        op(a, d, OP_BYP_PROG);
        op(19'h0, 16'h0, OP_BYP_RESET);
        op(a, 16'h0, OP_READ);
        rd(OFF_RESULT, {18'h0, d});
        op(19'h0, 16'h0, OP_SUSPEND);
        op(19'h0, 16'h0, OP_RESUME);
        rd(OFF_STATUS, 34'hc);
        $display("test fail erase bypass done");
        op(19'h0, 16'h0, OP_AUTOSELECT);
        rd(OFF_RESULT, 34'h00c3);
        op(19'h2, 16'h0, OP_AUTOSELECT);
        rd(OFF_RESULT, 34'h0);
        op(19'h0, 16'h0, OP_RESET);
        op(a, 16'h0, OP_READ);
        rd(OFF_RESULT, {18'h0, d});
        $display("test autoselect done");
        op(a, 16'h0, OP_CHIP_ERASE);
        rd(OFF_RESULT, 34'hffff);
        $display("test chip erase done");
        summarize();
    end
endmodule : flash_host_ctrl_tb
